// File: pkg/lcdr_regs.svh
`ifndef LCDR_REGS_SVH
`define LCDR_REGS_SVH
// ----------------------------------------
// Geometry and reset values
// ----------------------------------------
`define LCDR_COLS 80
`define LCDR_ROWS 4
`define LCDR_PTR_RST 0
`define LCDR_SUB_RST 3'h0
`define LCDR_LAST_BIT 3'h7
`define LCDR_BANK_OFS 2'h2
// ----------------------------------------
// Timing in ref_clk cycles
// ----------------------------------------
`define LCDR_FRAME_CYC 24
`define LCDR_BLINK1_DIV 768
`define LCDR_BLINK2_DIV 1536
`define LCDR_BLINK3_DIV 3072
`endif

// File: pkg/lcdr_pkg.sv
package lcdr_pkg;
	// ----------------------------------------
	// Drive modes and blink rates
	// ----------------------------------------
	typedef enum logic [1:0] {LCDR_STATIC, LCDR_DUPLEX, LCDR_TRIPLEX, LCDR_QUAD} lcdr_mode_type;
	typedef enum logic [1:0] {LCDR_BLINK_OFF, LCDR_BLINK_1, LCDR_BLINK_2, LCDR_BLINK_3}
		lcdr_blink_type;

	// Rows used per RAM word in each mode
	function automatic logic [2:0] lcdrRowsPerWord(input lcdr_mode_type m);
		case (m)
			LCDR_STATIC:  return 3'h1;
			LCDR_DUPLEX:  return 3'h2;
			LCDR_TRIPLEX: return 3'h3;
			default:      return 3'h4;
		endcase
	endfunction

	// Only static and duplex leave room for an alternate bank
	function automatic logic lcdrHasAltBank(input lcdr_mode_type m);
		return (m == LCDR_STATIC) || (m == LCDR_DUPLEX);
	endfunction
endpackage

// File: core/lcdr_blink_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcdr_regs.svh"
module lcdr_blink_gen
	import lcdr_pkg::*;
(
	input  wire logic           ref_clk,
	input  wire logic           rst_b,
	input  wire lcdr_blink_type blinkRate,
	output var  logic           blinkPhase_q
);
	logic [10:0] cnt_q;
	logic [10:0] half;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------
	// Half period per rate
	// ----------------------------------------
	always_comb
	begin
		case (blinkRate)
			LCDR_BLINK_1: half = 11'(`LCDR_BLINK1_DIV / 2);
			LCDR_BLINK_2: half = 11'(`LCDR_BLINK2_DIV / 2);
			LCDR_BLINK_3: half = 11'(`LCDR_BLINK3_DIV / 2);
			default:      half = 11'h000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_q        <= 11'h000;
			blinkPhase_q <= 1'b0;
		end
		else if (blinkRate == LCDR_BLINK_OFF)
		begin
			cnt_q        <= 11'h000;
			blinkPhase_q <= 1'b0;
		end
		else if (cnt_q >= half - 11'h001)
		begin
			cnt_q        <= 11'h000;
			blinkPhase_q <= ~blinkPhase_q;
		end
		else
			cnt_q <= cnt_q + 11'h001;
	end

	property p_blink_off;
		blinkRate == LCDR_BLINK_OFF |=> !blinkPhase_q;
	endproperty
	a_blink_off: assert property (p_blink_off) else $error("blink active while off");

	property p_blink_half;
		$changed(blinkPhase_q) && blinkRate == LCDR_BLINK_1 && $stable(blinkRate)
			|-> cnt_q == 11'h000 && $past(cnt_q) == 11'(`LCDR_BLINK1_DIV / 2 - 1);
	endproperty
	a_blink_half: assert property (p_blink_half) else $error("blink half period wrong");
endmodule // lcdr_blink_gen
`default_nettype wire

// File: core/lcdr_phase_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcdr_regs.svh"
module lcdr_phase_gen
	import lcdr_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          rst_b,
	input  wire lcdr_mode_type mode,
	input  wire logic          enable,
	output logic               rowLoad,
	output logic [1:0]         nextRow,
	output var  logic [3:0]    backplane_q
);
	logic [4:0] cycCnt_q;
	logic [1:0] row_q;
	logic [4:0] rowCyc;
	logic [2:0] rows;
	logic [3:0] bpNext;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------
	// Multiplex phase sequencing
	// ----------------------------------------
	always_comb
	begin
		rows    = lcdrRowsPerWord(mode);
		rowCyc  = 5'(`LCDR_FRAME_CYC / rows);
		rowLoad = cycCnt_q >= rowCyc - 5'h01;
		nextRow = ({1'b0, row_q} >= rows - 3'h1) ? 2'h0 : row_q + 2'h1;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cycCnt_q <= 5'h00;
			row_q    <= 2'h0;
		end
		else if (rowLoad)
		begin
			cycCnt_q <= 5'h00;
			row_q    <= nextRow;
		end
		else
			cycCnt_q <= cycCnt_q + 5'h01;
	end

	always_comb
	begin
		for (int i = 0; i < `LCDR_ROWS; i++)
		begin
			if (mode == LCDR_TRIPLEX && i == `LCDR_ROWS - 1)
				bpNext[i] = nextRow == 2'h1;
			else
				bpNext[i] = 3'(i) % rows == {1'b0, nextRow};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			backplane_q <= 4'h0;
		else if (rowLoad)
			backplane_q <= enable ? bpNext : 4'h0;
	end

	property p_bp_static;
		mode == LCDR_STATIC && enable && rowLoad |=> backplane_q == 4'hF;
	endproperty
	a_bp_static: assert property (p_bp_static) else $error("static backplanes differ");

	property p_bp_duplex;
		mode == LCDR_DUPLEX && rowLoad |=>
			backplane_q[0] == backplane_q[2] && backplane_q[1] == backplane_q[3];
	endproperty
	a_bp_duplex: assert property (p_bp_duplex) else $error("duplex pairs differ");

	property p_bp_triplex;
		mode == LCDR_TRIPLEX && rowLoad |=> backplane_q[3] == backplane_q[1];
	endproperty
	a_bp_triplex: assert property (p_bp_triplex) else $error("third mode bp3 not bp1");
endmodule // lcdr_phase_gen
`default_nettype wire

// File: core/lcdr_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcdr_regs.svh"
// Function
// - 80 words of 4 bits; a 1 lights the element, a 0 darkens it.
// - Rows 0-3 map to backplanes 0-3, columns 0-79 to segments.
// - Display register holds one row of all 80 columns per phase.
// - Backplanes mirror: bp3=bp1 triplex, pairs in duplex, all in static.
// - Each data bit is written on arrival, not at acknowledge.
// - Static mode puts eight bits into row 0 of eight words.
// - Duplex mode puts bit pairs into rows 0-1 of four words.
// - Triplex uses triples in rows 0-2 over three words; third word bit 2 kept.
// - Quad mode puts nibbles into rows 0-3 of two words.
// - Pointer load sets where the next display byte starts.
// - Pointer advances 8, 4, 3 or 2 per byte by mode.
// - Store only on subaddress match; pointer advances regardless.
// - Only the device-select command loads the subaddress counter.
// - Pointer overflow increments subaddress, even inside a byte.
// - Output rows scan 0-3, 0-2, 0-1 or 0 by mode.
// - Bank command shows rows 2/3 instead of 0/1 in static, duplex.
// - Input bank writes rows 2/3 in static, duplex; independent.
// - Blink off or clock divided by 768, 1536 or 3072.
// - Alternate-bank blink swaps banks at blink rate in static, duplex.
// - One register bit per segment output and memory column.
// - Reset clears pointer, subaddress, banks, blink; quad mode, display off.
module lcdr_core
	import lcdr_pkg::*;
#(
	parameter int COLS = `LCDR_COLS,
	parameter int PW   = $clog2(COLS)
)
(
	input  wire logic           ref_clk,
	input  wire logic           rst_b,
	input  wire logic           dataBitValid,
	input  wire logic           dataBit,
	input  wire logic           loadPtrValid,
	input  wire logic [PW-1:0]  loadPtrValue,
	input  wire logic           devSelValid,
	input  wire logic [2:0]     devSelValue,
	input  wire logic           modeSetValid,
	input  wire lcdr_mode_type  modeSetValue,
	input  wire logic           modeSetEnable,
	input  wire logic           bankSelValid,
	input  wire logic           bankSelInput,
	input  wire logic           bankSelOutput,
	input  wire logic           blinkSelValid,
	input  wire lcdr_blink_type blinkSelRate,
	input  wire logic           blinkSelAlt,
	input  wire logic           hwSubaddrBit0,
	input  wire logic           hwSubaddrBit1,
	input  wire logic           hwSubaddrBit2,
	output var  logic [COLS-1:0] segmentOut_q,
	output logic                backplaneOutZero,
	output logic                backplaneOutOne,
	output logic                backplaneOutTwo,
	output logic                backplaneOutThree,
	output var  logic [PW-1:0]  dataPtr_q,
	output var  logic [2:0]     subCnt_q,
	output var  logic           enable_q
);
	logic [3:0]     ram_q [COLS];
	logic [2:0]     bitCnt_q;
	logic [1:0]     rowIdx_q;
	lcdr_mode_type  mode_q;
	lcdr_blink_type blinkRate_q;
	logic           inBank_q;
	logic           outBank_q;
	logic           blinkAlt_q;
	logic [2:0]     rowsPer;
	logic           altOk;
	logic           subMatch;
	logic [1:0]     wrRow;
	logic           wordDone;
	logic           ptrLast;
	logic           advance;
	logic           rowLoad;
	logic [1:0]     nextRow;
	logic [1:0]     rdRow;
	logic           blinkPhase;
	logic           blank;
	logic [3:0]     backplane;
	logic [3:0]     curWord;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------
	// Write position decode
	// ----------------------------------------
	always_comb
	begin
		rowsPer  = lcdrRowsPerWord(mode_q);
		altOk    = lcdrHasAltBank(mode_q);
		subMatch = subCnt_q == {hwSubaddrBit2, hwSubaddrBit1, hwSubaddrBit0};
		wrRow    = rowIdx_q + ((inBank_q && altOk) ? `LCDR_BANK_OFS : 2'h0);
		wordDone = ({1'b0, rowIdx_q} == rowsPer - 3'h1) || (bitCnt_q == `LCDR_LAST_BIT);
		ptrLast  = dataPtr_q == PW'(COLS - 1);
		advance  = dataBitValid && wordDone;
		curWord  = ram_q[dataPtr_q];
	end

	// ----------------------------------------
	// Data pointer
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			dataPtr_q <= PW'(`LCDR_PTR_RST);
		else if (loadPtrValid)
			dataPtr_q <= loadPtrValue;
		else if (advance)
			dataPtr_q <= ptrLast ? PW'(`LCDR_PTR_RST) : dataPtr_q + PW'(1);
	end

	// Position inside the byte; a load realigns it, so an aborted byte
	// leaves a stale position until the host reloads the pointer.
	// realign on reload
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bitCnt_q <= 3'h0;
			rowIdx_q <= 2'h0;
		end
		else if (loadPtrValid)
		begin
			bitCnt_q <= 3'h0;
			rowIdx_q <= 2'h0;
		end
		else if (dataBitValid)
		begin
			bitCnt_q <= bitCnt_q + 3'h1;
			rowIdx_q <= wordDone ? 2'h0 : rowIdx_q + 2'h1;
		end
	end

	// ----------------------------------------
	// Subaddress counter
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			subCnt_q <= `LCDR_SUB_RST;
		else if (devSelValid)
			subCnt_q <= devSelValue;
		else if (advance && ptrLast && !loadPtrValid)
			subCnt_q <= subCnt_q + 3'h1;
	end

	// ----------------------------------------
	// Configuration
	// ----------------------------------------
	// power-on defaults
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_q      <= LCDR_QUAD;
			enable_q    <= 1'b0;
			inBank_q    <= 1'b0;
			outBank_q   <= 1'b0;
			blinkRate_q <= LCDR_BLINK_OFF;
			blinkAlt_q  <= 1'b0;
		end
		else
		begin
			if (modeSetValid)
			begin
				mode_q   <= modeSetValue;
				enable_q <= modeSetEnable;
			end
			if (bankSelValid)
			begin
				inBank_q  <= bankSelInput;
				outBank_q <= bankSelOutput;
			end
			if (blinkSelValid)
			begin
				blinkRate_q <= blinkSelRate;
				blinkAlt_q  <= blinkSelAlt;
			end
		end
	end

	// ----------------------------------------
	// Display RAM and display register
	// ----------------------------------------
	always_comb
	begin
		rdRow = nextRow + ((altOk && (outBank_q ^ (blinkAlt_q && blinkPhase)))
			? `LCDR_BANK_OFS : 2'h0);
		blank = !enable_q || (blinkPhase && !(blinkAlt_q && altOk));
	end

	// Flops rather than a macro keep every column readable in parallel
	// for the display register load.
	for (genvar c = 0; c < COLS; c++)
	begin : g_col
		always_ff @(posedge ref_clk or negedge rst_b)
		begin
			if (!rst_b)
				ram_q[c] <= 4'h0;
			else if (dataBitValid && subMatch && !loadPtrValid && dataPtr_q == PW'(c))
				ram_q[c][wrRow] <= dataBit;
		end

		always_ff @(posedge ref_clk or negedge rst_b)
		begin
			if (!rst_b)
				segmentOut_q[c] <= 1'b0;
			else if (rowLoad)
				segmentOut_q[c] <= ram_q[c][rdRow] && !blank;
		end
	end

	lcdr_phase_gen u_phase (
		.ref_clk     (ref_clk),
		.rst_b       (rst_b),
		.mode        (mode_q),
		.enable      (enable_q),
		.rowLoad     (rowLoad),
		.nextRow     (nextRow),
		.backplane_q (backplane)
	);

	lcdr_blink_gen u_blink (
		.ref_clk      (ref_clk),
		.rst_b        (rst_b),
		.blinkRate    (blinkRate_q),
		.blinkPhase_q (blinkPhase)
	);

	assign backplaneOutZero  = backplane[0];
	assign backplaneOutOne   = backplane[1];
	assign backplaneOutTwo   = backplane[2];
	assign backplaneOutThree = backplane[3];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_ptr_range;
		dataPtr_q <= PW'(COLS - 1) || $past(loadPtrValid);
	endproperty
	a_ptr_range: assert property (p_ptr_range) else $error("pointer out of range");

	property p_overflow;
		advance && ptrLast && !loadPtrValid && !devSelValid
			|=> dataPtr_q == '0 && subCnt_q == $past(subCnt_q) + 3'h1;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not cascaded");

	property p_load_ptr;
		loadPtrValid |=> dataPtr_q == $past(loadPtrValue) && bitCnt_q == 3'h0;
	endproperty
	a_load_ptr: assert property (p_load_ptr) else $error("pointer load lost");

	property p_dev_sel;
		devSelValid |=> subCnt_q == $past(devSelValue);
	endproperty
	a_dev_sel: assert property (p_dev_sel) else $error("subaddress load lost");

	property p_store;
		dataBitValid && subMatch && !loadPtrValid
			|=> ram_q[$past(dataPtr_q)][$past(wrRow)] == $past(dataBit);
	endproperty
	a_store: assert property (p_store) else $error("data bit not stored");

	property p_no_store;
		dataBitValid && !subMatch |=> ram_q[$past(dataPtr_q)] == $past(curWord);
	endproperty
	a_no_store: assert property (p_no_store) else $error("store on mismatch");

	property p_triplex_bit3;
		dataBitValid && mode_q == LCDR_TRIPLEX |=> ram_q[$past(dataPtr_q)][3] == $past(curWord[3]);
	endproperty
	a_triplex_bit3: assert property (p_triplex_bit3) else $error("bit 3 touched");

	property p_quad_byte;
		mode_q == LCDR_QUAD && dataBitValid && bitCnt_q == 3'h3 && !loadPtrValid |-> advance;
	endproperty
	a_quad_byte: assert property (p_quad_byte) else $error("quad nibble not closed");

	c_overflow: cover property (advance && ptrLast && subMatch);
	c_alt_swap: cover property (blinkAlt_q && altOk && $changed(blinkPhase));
	c_static_write: cover property (mode_q == LCDR_STATIC && dataBitValid && inBank_q);
	c_mismatch: cover property (dataBitValid && !subMatch);
endmodule // lcdr_core
`default_nettype wire

// File: verification/lcdr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module lcdr_host_model
	import lcdr_pkg::*;
(
	input  wire logic      ref_clk,
	output var  logic      dataBitValid,
	output var  logic      dataBit,
	output var  logic      loadPtrValid,
	output var  logic [6:0] loadPtrValue,
	output var  logic      devSelValid,
	output var  logic [2:0] devSelValue,
	output var  logic      modeSetValid,
	output var  lcdr_mode_type modeSetValue,
	output var  logic      modeSetEnable,
	output var  logic      bankSelValid,
	output var  logic      bankSelInput,
	output var  logic      bankSelOutput,
	output var  logic      blinkSelValid,
	output var  lcdr_blink_type blinkSelRate,
	output var  logic      blinkSelAlt,
	output var  logic [2:0] hwSubaddr
);
	// ----------------------------------------
	// Decoder side of the command group
	// ----------------------------------------
	initial
	begin
		{dataBitValid, dataBit, loadPtrValid, loadPtrValue, devSelValid, devSelValue} = '0;
		{modeSetValid, modeSetEnable, bankSelValid, bankSelInput, bankSelOutput} = '0;
		{blinkSelValid, blinkSelAlt, hwSubaddr} = '0;
		modeSetValue = LCDR_QUAD;
		blinkSelRate = LCDR_BLINK_OFF;
	end

	// whole bytes, MSB first
	// Never cut short, so the pointer always stays defined
	task automatic sendByte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			@(posedge ref_clk);
			dataBitValid <= 1'b1;
			dataBit      <= b[i];
		end
		@(posedge ref_clk);
		dataBitValid <= 1'b0;
	endtask

	task automatic loadPtr(input logic [6:0] v);
		@(posedge ref_clk);
		loadPtrValid <= 1'b1;
		loadPtrValue <= v;
		@(posedge ref_clk);
		loadPtrValid <= 1'b0;
	endtask

	task automatic devSel(input logic [2:0] v);
		@(posedge ref_clk);
		devSelValid <= 1'b1;
		devSelValue <= v;
		@(posedge ref_clk);
		devSelValid <= 1'b0;
	endtask

	task automatic setMode(input lcdr_mode_type m, input logic en);
		@(posedge ref_clk);
		modeSetValid  <= 1'b1;
		modeSetValue  <= m;
		modeSetEnable <= en;
		@(posedge ref_clk);
		modeSetValid <= 1'b0;
	endtask

	task automatic setBank(input logic bin, input logic bout);
		@(posedge ref_clk);
		bankSelValid  <= 1'b1;
		bankSelInput  <= bin;
		bankSelOutput <= bout;
		@(posedge ref_clk);
		bankSelValid <= 1'b0;
	endtask

	task automatic setBlink(input lcdr_blink_type r, input logic alt);
		@(posedge ref_clk);
		blinkSelValid <= 1'b1;
		blinkSelRate  <= r;
		blinkSelAlt   <= alt;
		@(posedge ref_clk);
		blinkSelValid <= 1'b0;
	endtask

	task automatic setHw(input logic [2:0] v);
		@(posedge ref_clk);
		hwSubaddr <= v;
	endtask
endmodule // lcdr_host_model
`default_nettype wire

// File: verification/lcdr_core_test.sv
`timescale 1ns/100ps
`default_nettype none
module lcdr_core_test
	import lcdr_pkg::*;
;
	logic ref_clk, rst_b, dataBitValid, dataBit, loadPtrValid, devSelValid, modeSetValid;
	logic modeSetEnable, bankSelValid, bankSelInput, bankSelOutput, blinkSelValid, blinkSelAlt;
	logic [6:0] loadPtrValue, dataPtr_q;
	logic [2:0] devSelValue, hwSubaddr, subCnt_q;
	lcdr_mode_type modeSetValue;
	lcdr_blink_type blinkSelRate;
	logic [79:0] segmentOut_q, s;
	logic backplaneOutZero, backplaneOutOne, backplaneOutTwo, backplaneOutThree, enable_q;
	logic [3:0] bpVec;
	int err_count = 0;
	int checks = 0;
	int cnt;
	int step[4] = '{8, 4, 3, 2};
	logic [3:0] bpPat[4] = '{4'hF, 4'h5, 4'hA, 4'h8};
	assign bpVec = {backplaneOutThree, backplaneOutTwo, backplaneOutOne, backplaneOutZero};

	lcdr_core u_lcdr_core (
		.ref_clk           (ref_clk),
		.rst_b             (rst_b),
		.dataBitValid      (dataBitValid),
		.dataBit           (dataBit),
		.loadPtrValid      (loadPtrValid),
		.loadPtrValue      (loadPtrValue),
		.devSelValid       (devSelValid),
		.devSelValue       (devSelValue),
		.modeSetValid      (modeSetValid),
		.modeSetValue      (modeSetValue),
		.modeSetEnable     (modeSetEnable),
		.bankSelValid      (bankSelValid),
		.bankSelInput      (bankSelInput),
		.bankSelOutput     (bankSelOutput),
		.blinkSelValid     (blinkSelValid),
		.blinkSelRate      (blinkSelRate),
		.blinkSelAlt       (blinkSelAlt),
		.hwSubaddrBit0     (hwSubaddr[0]),
		.hwSubaddrBit1     (hwSubaddr[1]),
		.hwSubaddrBit2     (hwSubaddr[2]),
		.segmentOut_q      (segmentOut_q),
		.backplaneOutZero  (backplaneOutZero),
		.backplaneOutOne   (backplaneOutOne),
		.backplaneOutTwo   (backplaneOutTwo),
		.backplaneOutThree (backplaneOutThree),
		.dataPtr_q         (dataPtr_q),
		.subCnt_q          (subCnt_q),
		.enable_q          (enable_q)
	);
	lcdr_host_model u_lcdr_host_model (
		.ref_clk       (ref_clk),
		.dataBitValid  (dataBitValid),
		.dataBit       (dataBit),
		.loadPtrValid  (loadPtrValid),
		.loadPtrValue  (loadPtrValue),
		.devSelValid   (devSelValid),
		.devSelValue   (devSelValue),
		.modeSetValid  (modeSetValid),
		.modeSetValue  (modeSetValue),
		.modeSetEnable (modeSetEnable),
		.bankSelValid  (bankSelValid),
		.bankSelInput  (bankSelInput),
		.bankSelOutput (bankSelOutput),
		.blinkSelValid (blinkSelValid),
		.blinkSelRate  (blinkSelRate),
		.blinkSelAlt   (blinkSelAlt),
		.hwSubaddr     (hwSubaddr)
	);

	// ----------------------------------------
	// Clock, checks and helpers
	// ----------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic cmpVal(input string what, input logic [79:0] exp, input logic [79:0] got);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// Waits for a fresh entry into a backplane pattern, so the row holds current RAM
	task automatic rowSeg(input logic [3:0] bp, output logic [79:0] sg);
		int n;
		n = 0;
		while (bpVec === bp && n < 200)
		begin
			@(negedge ref_clk);
			n++;
		end
		while (bpVec !== bp && n < 200)
		begin
			@(negedge ref_clk);
			n++;
		end
		cmpVal("row entered", 80'(bp), 80'(bpVec));
		sg = segmentOut_q;
	endtask

	// Counts frames of one blank phase of the two low columns in row 0
	task automatic blankRun(output int c);
		int n;
		c = 0;
		n = 0;
		rowSeg(4'h1, s);
		while (s[1:0] === 2'b00 && n < 300)
		begin
			rowSeg(4'h1, s);
			n++;
		end
		while (s[1:0] !== 2'b00 && n < 300)
		begin
			rowSeg(4'h1, s);
			n++;
		end
		while (s[1:0] === 2'b00 && n < 300)
		begin
			c++;
			rowSeg(4'h1, s);
			n++;
		end
	endtask

	initial
	begin
		repeat (40000) @(posedge ref_clk);
		err_count++;
		$display("[ERR] watchdog expired");
		final_report();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		rst_b = 1'b0;
		repeat (20) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(negedge ref_clk);
		cmpVal("reset state", 80'h0, 80'({enable_q, subCnt_q, dataPtr_q, bpVec}));
		cmpVal("reset segments", 80'h0, segmentOut_q);
		$display("test reset done");
		u_lcdr_host_model.setMode(LCDR_QUAD, 1'b1);
		u_lcdr_host_model.loadPtr(7'h00);
		u_lcdr_host_model.sendByte(8'hA5);
		@(negedge ref_clk);
		cmpVal("quad pointer", 80'h2, 80'(dataPtr_q));
		for (int r = 0; r < 4; r++)
		begin
			rowSeg(4'h1 << r, s);
			cmpVal("quad row", (r % 2 == 0) ? 80'h1 : 80'h2, 80'(s[1:0]));
		end
		$display("test quad store done");
		for (int m = 0; m < 4; m++)
		begin
			u_lcdr_host_model.setMode(lcdr_mode_type'(m), 1'b1);
			u_lcdr_host_model.loadPtr(7'h28);
			u_lcdr_host_model.sendByte(8'h00);
			@(negedge ref_clk);
			cmpVal("advance", 80'(40 + step[m]), 80'(dataPtr_q));
			rowSeg(bpPat[m], s);
		end
		$display("test advance done");
		u_lcdr_host_model.setMode(LCDR_QUAD, 1'b1);
		u_lcdr_host_model.loadPtr(7'h14);
		u_lcdr_host_model.sendByte(8'hFF);
		u_lcdr_host_model.setMode(LCDR_TRIPLEX, 1'b1);
		u_lcdr_host_model.loadPtr(7'h14);
		u_lcdr_host_model.sendByte(8'h00);
		u_lcdr_host_model.setMode(LCDR_QUAD, 1'b1);
		rowSeg(4'h8, s);
		cmpVal("triplex keeps row3", 80'h3, 80'(s[21:20]));
		rowSeg(4'h1, s);
		cmpVal("triplex row0", 80'h0, 80'(s[22:20]));
		$display("test triplex done");
		u_lcdr_host_model.setMode(LCDR_STATIC, 1'b1);
		u_lcdr_host_model.setBank(1'b1, 1'b1);
		u_lcdr_host_model.loadPtr(7'h32);
		u_lcdr_host_model.sendByte(8'hC5);
		rowSeg(4'hF, s);
		cmpVal("static alt row", 80'hA3, 80'(s[57:50]));
		u_lcdr_host_model.setBank(1'b0, 1'b0);
		rowSeg(4'hF, s);
		cmpVal("static row0", 80'h0, 80'(s[57:50]));
		u_lcdr_host_model.setMode(LCDR_DUPLEX, 1'b1);
		u_lcdr_host_model.setBank(1'b1, 1'b0);
		u_lcdr_host_model.loadPtr(7'h0A);
		u_lcdr_host_model.sendByte(8'h9C);
		rowSeg(4'h5, s);
		cmpVal("input bank", 80'h0, 80'(s[13:10]));
		u_lcdr_host_model.setBank(1'b0, 1'b1);
		rowSeg(4'hA, s);
		cmpVal("output bank", 80'h6, 80'(s[13:10]));
		u_lcdr_host_model.setBank(1'b0, 1'b0);
		u_lcdr_host_model.setBlink(LCDR_BLINK_1, 1'b1);
		cnt = 0;
		s = '0;
		while (s[13:10] !== 4'h5 && cnt < 60)
		begin
			rowSeg(4'h5, s);
			cnt++;
		end
		cmpVal("alt blink", 80'h5, 80'(s[13:10]));
		$display("test banks done");
		u_lcdr_host_model.setMode(LCDR_QUAD, 1'b1);
		for (int r = 1; r < 4; r++)
		begin
			u_lcdr_host_model.setBlink(lcdr_blink_type'(r), 1'b0);
			blankRun(cnt);
			cmpVal("blink frames", 80'(16 << (r - 1)), 80'(cnt));
		end
		u_lcdr_host_model.setBlink(LCDR_BLINK_OFF, 1'b0);
		$display("test blink done");
		u_lcdr_host_model.devSel(3'h3);
		u_lcdr_host_model.loadPtr(7'h1E);
		u_lcdr_host_model.sendByte(8'hFF);
		@(negedge ref_clk);
		cmpVal("no match", 80'h3_20, 80'({subCnt_q, 1'b0, dataPtr_q}));
		rowSeg(4'h1, s);
		cmpVal("no store", 80'h0, 80'(s[31:30]));
		u_lcdr_host_model.setHw(3'h3);
		u_lcdr_host_model.loadPtr(7'h1E);
		u_lcdr_host_model.sendByte(8'hFF);
		rowSeg(4'h1, s);
		cmpVal("match store", 80'h3, 80'(s[31:30]));
		u_lcdr_host_model.setHw(3'h0);
		u_lcdr_host_model.devSel(3'h0);
		u_lcdr_host_model.loadPtr(7'h4F);
		u_lcdr_host_model.sendByte(8'hF0);
		@(negedge ref_clk);
		cmpVal("overflow", 80'h1_01, 80'({subCnt_q, 1'b0, dataPtr_q}));
		rowSeg(4'h1, s);
		cmpVal("wrap columns", 80'h3, 80'({s[79], s[0]}));
		$display("test subaddress done");
		final_report();
	end
endmodule // lcdr_core_test
`default_nettype wire
